// ===== rtu_framer_regs.svh
// Purpose: constants of the slave-side rtu framer: codes, gap figures, crc figures.
// Assumes: included by its bare name; definitions only.
// Notes: gap figures are in half character times.
// How it works
// - only one side drives the shared line.
// - own address 1..247, zero is broadcast.
// - one reply per addressed query, none broadcast.
// - 3.5 character idle before every frame.
// - first byte filters: own, broadcast, else ignore.
// - 3.5 character silence closes the frame.
// - gap above 1.5 restarts at address byte.
// - short gap appends; crc then rejects it.
// - frame is address, command, data, crc.
// - read word count 1..12, else error.
// - read reply: echo, byte count, words, crc.
// - bad command, length, count or store access answered by an error reply frame.
// - crc appended by sender, checked by receiver.
// - only eight data bits enter the crc.
// - preset ones, shift right, xor 0xa001.
// - crc sent low byte then high byte.
// - address high byte group, low byte index.
`ifndef RTU_FRAMER_REGS_SVH
`define RTU_FRAMER_REGS_SVH
`define ADDR_BROADCAST   8'h00
`define ADDR_MIN         8'h01
`define ADDR_MAX         8'hf7
`define CMD_READ         8'h03
`define CMD_WRITE        8'h06
`define CMD_ERR_FLAG     8'h80
`define ERR_BAD_CMD      8'h01
`define ERR_BAD_ADDR     8'h02
`define ERR_BAD_DATA     8'h03
`define READ_MAX_WORDS   16'h000c
`define REQ_LEN          5'h08
`define MIN_LEN          5'h04
`define RBUF_DEPTH       5'h08
`define CRC_PRESET       16'hffff
`define CRC_POLY         16'ha001
`define CRC_BITS         8
`define GAP_SHORT_HALVES 8'h03
`define GAP_LONG_HALVES  8'h07
`define RESP_HDR_LEN     5'h03
`endif

// ===== rtu_framer_pkg.sv
// Purpose: types shared by the rtu framer modules.
// Assumes: used only by scoped names, never imported.
// Notes: encodings written out so waveforms read the same everywhere.
package rtu_framer_pkg;
  typedef enum logic [2:0] {
    ST_WAIT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_RX    = 3'b010,
    ST_DROP  = 3'b011,
    ST_EXEC  = 3'b100,
    ST_PARAM = 3'b101,
    ST_TX    = 3'b110
  } fsm_e;
  typedef enum logic [1:0] {
    RESP_READ  = 2'b00,
    RESP_WRITE = 2'b01,
    RESP_ERROR = 2'b10
  } resp_e;
endpackage

// ===== crc16_byte.sv
// Purpose: one byte step of the 16-bit frame check.
// Assumes: purely combinational; caller holds the register.
// Notes: only the data byte enters, framing bits never reach here.
`include "rtu_framer_regs.svh"
module crc16_byte
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  // xor into low bits, then eight right shifts with poly on a one out
  always_comb
  begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (int i = 0; i < `CRC_BITS; i++)
    begin
      if (crc_out[0])
        crc_out = (crc_out >> 1) ^ `CRC_POLY;
      else
        crc_out = crc_out >> 1;
    end
  end
endmodule

// ===== rtu_gap_timer.sv
// Purpose: measures line silence in character times.
// Assumes: activity_in pulses once per finished character on the line.
// Notes: baud_div_in is clocks per bit; char_bits_in counts start, data, parity, stop.
`include "rtu_framer_regs.svh"
module rtu_gap_timer
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] baud_div_in,
  input  wire logic [3:0]  char_bits_in,
  input  wire logic        activity_in,
  output logic             gap_short_out,
  output logic             gap_long_out
);
  typedef struct packed {
    logic [15:0] div;
    logic [7:0]  bits;
  } timer_s;

  timer_s s;
  timer_s next_s;
  logic [7:0] short_bits;
  logic [7:0] long_bits;

  // thresholds rounded up so a gap is never declared early
  always_comb
  begin
    short_bits = 8'((8'(char_bits_in) * `GAP_SHORT_HALVES + 8'h01) >> 1);
    long_bits  = 8'((8'(char_bits_in) * `GAP_LONG_HALVES + 8'h01) >> 1);
  end

  // bit tick divider and saturating bit counter, cleared by activity
  always_comb
  begin
    next_s = s;
    if (activity_in)
    begin
      next_s.div  = 16'h0000;
      next_s.bits = 8'h00;
    end
    else if (s.div + 16'h0001 >= baud_div_in)
    begin
      next_s.div = 16'h0000;
      if (s.bits != 8'hff)
        next_s.bits = s.bits + 8'h01;
    end
    else
      next_s.div = s.div + 16'h0001;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '0;
    else
      s <= next_s;
  end

  assign gap_short_out = (s.bits >= short_bits);
  assign gap_long_out  = (s.bits >= long_bits);
endmodule

// ===== rtu_slave_framer.sv
// Purpose: slave frame receiver, command decoder and reply former.
// Assumes: a uart delivers and takes whole bytes; parameter store answers by ack.
// Notes: replies leave only after a closed query, so the line is already quiet.
`include "rtu_framer_regs.svh"
module rtu_slave_framer
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  own_address_setting_in,
  input  wire logic [15:0] baud_div_in,
  input  wire logic [3:0]  char_bits_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_valid_in,
  output logic      [7:0]  tx_byte_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic             tx_enable_out,
  output logic             param_req_out,
  output logic             param_we_out,
  output logic      [7:0]  param_group_out,
  output logic      [7:0]  param_index_out,
  output logic      [15:0] param_wdata_out,
  input  wire logic        param_ack_in,
  input  wire logic        param_err_in,
  input  wire logic [15:0] param_rdata_in
);
  typedef struct packed {
    rtu_framer_pkg::fsm_e      state;
    logic                      bcast;
    logic [4:0]                cnt;
    logic [7:0][7:0]           rbuf;
    logic [15:0]               crc;
    rtu_framer_pkg::resp_e     kind;
    logic [7:0]                code;
    logic [3:0]                wcnt;
    logic [3:0]                wi;
    logic [11:0][15:0]         words;
    logic                      req;
    logic                      we;
    logic [15:0]               paddr;
    logic [4:0]                plen;
    logic [4:0]                tx_idx;
    logic [7:0]                tx_byte;
    logic                      tx_valid;
    logic [15:0]               tx_crc;
  } framer_s;

  framer_s     s;
  framer_s     next_s;
  logic        gap_short;
  logic        gap_long;
  logic        line_event;
  logic        addr_hit;
  logic        new_frame;
  logic [15:0] rx_crc_src;
  logic [15:0] rx_crc_next;
  logic [15:0] tx_crc_next;
  logic [7:0]  tx_pick;
  logic [4:0]  rd_off;
  logic [15:0] rd_word;
  logic [15:0] req_count;

  // prepare a reply: kind, payload length and a fresh check register
  function automatic framer_s start_reply(framer_s v, rtu_framer_pkg::resp_e k,
                                          logic [4:0] len);
    framer_s r;
    r          = v;
    r.kind     = k;
    r.plen     = len;
    r.tx_idx   = 5'h00;
    r.tx_valid = 1'b0;
    r.tx_crc   = `CRC_PRESET;
    r.req      = 1'b0;
    r.state    = v.bcast ? rtu_framer_pkg::ST_IDLE : rtu_framer_pkg::ST_TX;
    return r;
  endfunction

  // error reply with a reason; broadcasts stay silent
  function automatic framer_s fail(framer_s v, logic [7:0] reason);
    framer_s r;
    r      = v;
    r.code = reason;
    return start_reply(r, rtu_framer_pkg::RESP_ERROR, `RESP_HDR_LEN);
  endfunction

  rtu_gap_timer gap_timer
  (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .baud_div_in   (baud_div_in),
    .char_bits_in  (char_bits_in),
    .activity_in   (line_event),
    .gap_short_out (gap_short),
    .gap_long_out  (gap_long)
  );

  crc16_byte rx_crc
  (
    .crc_in  (rx_crc_src),
    .data_in (rx_byte_in),
    .crc_out (rx_crc_next)
  );

  crc16_byte tx_crc
  (
    .crc_in  (s.tx_crc),
    .data_in (tx_pick),
    .crc_out (tx_crc_next)
  );

  // every character on the wire, ours or the master's, restarts the silence count
  assign line_event = rx_valid_in | (s.tx_valid & tx_ready_in);

  // address filter: own address only when in the legal range, plus broadcast
  always_comb
  begin
    addr_hit = (rx_byte_in == `ADDR_BROADCAST) ||
               (rx_byte_in == own_address_setting_in &&
                own_address_setting_in >= `ADDR_MIN &&
                own_address_setting_in <= `ADDR_MAX);
  end

  // a byte opens a frame after idle, or after a mid-frame pause over 1.5 chars
  always_comb
  begin
    new_frame = rx_valid_in &&
                (s.state == rtu_framer_pkg::ST_IDLE ||
                 ((s.state == rtu_framer_pkg::ST_RX || s.state == rtu_framer_pkg::ST_DROP)
                  && gap_short));
    rx_crc_src = new_frame ? `CRC_PRESET : s.crc;
  end

  // reply byte for the current index, payload only; crc bytes come later
  always_comb
  begin
    rd_off  = 5'(s.tx_idx - `RESP_HDR_LEN);
    rd_word = s.words[rd_off[4:1]];
    tx_pick = s.rbuf[s.tx_idx[2:0]];
    case (s.kind)
      rtu_framer_pkg::RESP_READ:
      begin
        if (s.tx_idx == 5'h00)
          tx_pick = s.rbuf[0];
        else if (s.tx_idx == 5'h01)
          tx_pick = s.rbuf[1];
        else if (s.tx_idx == 5'h02)
          tx_pick = {3'h0, s.wcnt, 1'b0};
        else
          tx_pick = rd_off[0] ? rd_word[7:0] : rd_word[15:8];
      end
      rtu_framer_pkg::RESP_WRITE:
        tx_pick = s.rbuf[s.tx_idx[2:0]];
      rtu_framer_pkg::RESP_ERROR:
      begin
        if (s.tx_idx == 5'h00)
          tx_pick = s.rbuf[0];
        else if (s.tx_idx == 5'h01)
          tx_pick = s.rbuf[1] | `CMD_ERR_FLAG;
        else
          tx_pick = s.code;
      end
      default:
        tx_pick = 8'h00;
    endcase
  end

  assign req_count = {s.rbuf[4], s.rbuf[5]};

  // main sequencer: receive, check, execute, answer
  always_comb
  begin
    next_s = s;
    if (new_frame)
    begin
      // first byte is the address; foreign frames are skipped until silence
      next_s.cnt     = 5'h01;
      next_s.rbuf[0] = rx_byte_in;
      next_s.crc     = rx_crc_next;
      next_s.bcast   = (rx_byte_in == `ADDR_BROADCAST);
      next_s.state   = addr_hit ? rtu_framer_pkg::ST_RX : rtu_framer_pkg::ST_DROP;
    end
    else
    begin
      case (s.state)
        rtu_framer_pkg::ST_WAIT:
        begin
          // hold off until the line has been quiet a full frame gap
          if (gap_long)
            next_s.state = rtu_framer_pkg::ST_IDLE;
        end
        rtu_framer_pkg::ST_IDLE:
          next_s.state = rtu_framer_pkg::ST_IDLE;
        rtu_framer_pkg::ST_RX:
        begin
          if (rx_valid_in)
          begin
            // late bytes still join the frame; the crc then fails it
            next_s.crc = rx_crc_next;
            if (s.cnt < `RBUF_DEPTH)
              next_s.rbuf[s.cnt[2:0]] = rx_byte_in;
            if (s.cnt != 5'h1f)
              next_s.cnt = s.cnt + 5'h01;
          end
          else if (gap_long)
            next_s.state = rtu_framer_pkg::ST_EXEC;
        end
        rtu_framer_pkg::ST_DROP:
        begin
          if (gap_long)
            next_s.state = rtu_framer_pkg::ST_IDLE;
        end
        rtu_framer_pkg::ST_EXEC:
        begin
          // a correct frame leaves a zero residue over data and check bytes
          if (s.crc != 16'h0000 || s.cnt < `MIN_LEN)
            next_s.state = rtu_framer_pkg::ST_IDLE;
          else if (s.rbuf[1] != `CMD_READ && s.rbuf[1] != `CMD_WRITE)
            next_s = fail(s, `ERR_BAD_CMD);
          else if (s.cnt != `REQ_LEN)
            next_s = fail(s, `ERR_BAD_DATA);
          else if (s.rbuf[1] == `CMD_READ &&
                   (req_count == 16'h0000 || req_count > `READ_MAX_WORDS))
            next_s = fail(s, `ERR_BAD_DATA);
          else if (s.rbuf[1] == `CMD_READ && s.bcast)
            next_s.state = rtu_framer_pkg::ST_IDLE;
          else
          begin
            next_s.wcnt  = req_count[3:0];
            next_s.wi    = 4'h0;
            next_s.we    = (s.rbuf[1] == `CMD_WRITE);
            next_s.paddr = {s.rbuf[2], s.rbuf[3]};
            next_s.req   = 1'b1;
            next_s.state = rtu_framer_pkg::ST_PARAM;
          end
        end
        rtu_framer_pkg::ST_PARAM:
        begin
          // one store access per word; request stands until acknowledged
          if (param_ack_in)
          begin
            next_s.req = 1'b0;
            if (param_err_in)
              next_s = fail(s, `ERR_BAD_ADDR);
            else if (s.we)
              next_s = start_reply(s, rtu_framer_pkg::RESP_WRITE, 5'h06);
            else
            begin
              next_s.words[s.wi] = param_rdata_in;
              if (s.wi + 4'h1 == s.wcnt)
                next_s = start_reply(next_s, rtu_framer_pkg::RESP_READ,
                                     5'(`RESP_HDR_LEN + {s.wcnt, 1'b0}));
              else
              begin
                next_s.wi    = s.wi + 4'h1;
                next_s.paddr = s.paddr + 16'h0001;
                next_s.req   = 1'b1;
              end
            end
          end
        end
        rtu_framer_pkg::ST_TX:
        begin
          // one byte offered at a time; check bytes go low first
          if (s.tx_valid)
          begin
            if (tx_ready_in)
            begin
              next_s.tx_valid = 1'b0;
              if (s.tx_idx == 5'(s.plen + 5'h01))
                next_s.state = rtu_framer_pkg::ST_WAIT;
              else
                next_s.tx_idx = s.tx_idx + 5'h01;
            end
          end
          else
          begin
            next_s.tx_valid = 1'b1;
            if (s.tx_idx < s.plen)
            begin
              next_s.tx_byte = tx_pick;
              next_s.tx_crc  = tx_crc_next;
            end
            else if (s.tx_idx == s.plen)
              next_s.tx_byte = s.tx_crc[7:0];
            else
              next_s.tx_byte = s.tx_crc[15:8];
          end
        end
        default:
          next_s.state = rtu_framer_pkg::ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      s <= '0;
    else
      s <= next_s;
  end

  // bytes arriving while we talk are ignored; the driver is on only in tx
  assign tx_enable_out   = (s.state == rtu_framer_pkg::ST_TX);
  assign tx_byte_out     = s.tx_byte;
  assign tx_valid_out    = s.tx_valid;
  assign param_req_out   = s.req;
  assign param_we_out    = s.we;
  assign param_group_out = s.paddr[15:8];
  assign param_index_out = s.paddr[7:0];
  assign param_wdata_out = {s.rbuf[4], s.rbuf[5]};
endmodule

// ===== rtu_framer_chk.sv
// Purpose: port-level checks of the slave rtu framer.
// Assumes: one clock domain; reset is async active low.
// Notes: silence bound allows one bit time of slack; the bit tick is cleared by each character.
module rtu_framer_chk
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] baud_div_in,
  input wire logic [3:0]  char_bits_in,
  input wire logic        rx_valid_in,
  input wire logic [7:0]  tx_byte_out,
  input wire logic        tx_valid_out,
  input wire logic        tx_ready_in,
  input wire logic        tx_enable_out,
  input wire logic        param_req_out,
  input wire logic        param_we_out,
  input wire logic [7:0]  param_group_out,
  input wire logic [7:0]  param_index_out,
  input wire logic        param_ack_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] quiet;
  logic        heard;
  logic [15:0] need;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // clocks since the last received character; saturates so long idles stay legal
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      quiet <= 16'h0000;
      heard <= 1'b0;
    end
    else
    begin
      quiet <= rx_valid_in ? 16'h0000 : (quiet == 16'hffff ? quiet : quiet + 16'h0001);
      heard <= rx_valid_in ? 1'b1 : (tx_enable_out ? 1'b0 : heard);
    end
  end
  // long silence in clocks, less one bit of slack
  always_comb
    need = ((({12'h000, char_bits_in} * 16'h0007 + 16'h0001) >> 1) - 16'h0001)
           * ((baud_div_in > 16'h0001) ? baud_div_in : 16'h0001);
  sequence s_offer;
    tx_valid_out && !tx_ready_in;
  endsequence
  sequence s_take;
    tx_valid_out && tx_ready_in;
  endsequence
  property p_offer_hold;
    s_offer |=> tx_valid_out && $stable(tx_byte_out);
  endproperty
  a_offer_hold: assert property (p_offer_hold)
    else $error("reply byte dropped or changed before taken");
  property p_take_drop;
    s_take |=> !tx_valid_out;
  endproperty
  a_take_drop: assert property (p_take_drop)
    else $error("reply valid stayed high after take");
  property p_drive_only;
    tx_valid_out |-> tx_enable_out;
  endproperty
  a_drive_only: assert property (p_drive_only)
    else $error("byte offered with driver off");
  property p_quiet_first;
    $rose(tx_enable_out) |-> quiet >= need;
  endproperty
  a_quiet_first: assert property (p_quiet_first)
    else $error("reply started before long silence");
  property p_prompted;
    $rose(tx_enable_out) |-> heard;
  endproperty
  a_prompted: assert property (p_prompted)
    else $error("reply without a received query");
  property p_start;
    $rose(tx_enable_out) |=> tx_valid_out;
  endproperty
  a_start: assert property (p_start)
    else $error("first reply byte late");
  property p_end;
    $fell(tx_enable_out) |-> ($past(tx_valid_out) && $past(tx_ready_in))
      || ($past(tx_valid_out, 2) && $past(tx_ready_in, 2));
  endproperty
  a_end: assert property (p_end)
    else $error("driver off not right after last byte");
  property p_req_hold;
    param_req_out && !param_ack_in |=> param_req_out && $stable(param_we_out)
      && $stable(param_group_out) && $stable(param_index_out);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("store request changed before ack");
  property p_write_once;
    param_req_out && param_ack_in && param_we_out |=> !param_req_out;
  endproperty
  a_write_once: assert property (p_write_once)
    else $error("write request held after ack");
endmodule

// ===== rtu_master_model.sv
// Purpose: single bus master and its uart, seen at byte level.
// Assumes: bytes are spaced one 11-bit character at baud_div 2 (22 clocks).
// Notes: ready stalls one cycle in three so slow acceptance is exercised.
module rtu_master_model
(
  input  wire logic       clk_in,
  output logic      [7:0] rx_byte_out,
  output logic            rx_valid_out,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] q8_t[$];
  q8_t got;
  int  stall = 0;
  initial
  begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // only the master opens a transaction, after an idle gap, only data bytes
  task automatic send(input q8_t b, input int first_gap);
    repeat (first_gap) @(negedge clk_in);
    foreach (b[i])
    begin
      if (i > 0)
        repeat (21) @(negedge clk_in);
      rx_byte_out = b[i];
      rx_valid_out = 1'b1;
      @(negedge clk_in);
      rx_valid_out = 1'b0;
      rx_byte_out = ~b[i]; // stale data never looks valid
    end
  endtask
  // acceptance pattern, prompt twice then one stall
  always @(negedge clk_in)
  begin
    stall <= stall + 1;
    tx_ready_out <= (stall % 3) != 0;
  end
  // collect reply bytes; the master only listens meanwhile
  always @(posedge clk_in)
    if (tx_valid_in && tx_ready_out)
      got.push_back(tx_byte_in);
endmodule

// ===== modbus_rtu_slave_framer_tb.sv
// Purpose: self-checking bench for the slave rtu framer.
// Assumes: baud_div 2 and 11-bit characters keep the gaps short.
// Notes: the parameter store answers with the swapped address as data.
module modbus_rtu_slave_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] q8_t[$];
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  own = 8'h11;
  logic [7:0]  rx_byte, tx_byte, param_group, param_index;
  logic        rx_valid, tx_valid, tx_ready, tx_enable, param_req, param_we;
  logic        param_ack = 1'b0, param_err = 1'b0, store_err = 1'b0;
  logic [15:0] param_wdata, param_rdata = 16'h0000;
  logic [31:0] last_wr = 32'h0000_0000;
  int          failures = 0, checks_done = 0, reqs = 0;
  q8_t         none;
  always #4 clk_in = ~clk_in;
  rtu_slave_framer dut
  (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .own_address_setting_in(own),
    .baud_div_in(16'h0002), .char_bits_in(4'hb), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .tx_enable_out(tx_enable), .param_req_out(param_req), .param_we_out(param_we),
    .param_group_out(param_group), .param_index_out(param_index),
    .param_wdata_out(param_wdata), .param_ack_in(param_ack), .param_err_in(param_err),
    .param_rdata_in(param_rdata)
  );
  rtu_master_model mst
  (
    .clk_in(clk_in), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .tx_byte_in(tx_byte), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready)
  );
  // parameter store: acks on the same falling edge that first sees a request, logs writes
  always @(negedge clk_in)
  begin
    param_ack <= param_req && !param_ack;
    param_err <= param_req && !param_ack && store_err;
    param_rdata <= {param_index, param_group};
    if (param_req && !param_ack && param_we)
      last_wr = {param_group, param_index, param_wdata};
    if (param_req && !param_ack)
      reqs++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reference frame check: all ones preset, right shift, 0xa001
  function automatic q8_t frm(input q8_t b);
    logic [15:0] c = 16'hffff;
    foreach (b[i])
    begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return {b, c[7:0], c[15:8]};
  endfunction
  // waits out the closing silence, then for the whole reply under a bound
  task automatic expect_reply(input q8_t exp);
    int n = 0;
    repeat (150) @(negedge clk_in);
    while ((mst.got.size() < exp.size() || tx_enable) && n < 3000)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n == 3000)
    begin
      failures++;
      print_verdict();
    end
    check(mst.got.size(), exp.size());
    foreach (exp[i])
      check((i < mst.got.size()) ? mst.got[i] : 8'hxx, exp[i]);
    mst.got.delete();
  endtask
  task automatic t_read(input logic [7:0] n);
    q8_t exp = {own, 8'h03, 8'(2 * n)};
    for (int i = 0; i < n; i++)
      exp = {exp, 8'h03 + 8'(i), 8'hf0};
    mst.send(frm({own, 8'h03, 8'hf0, 8'h03, 8'h00, n}), 90);
    expect_reply(frm(exp));
  endtask
  task automatic t_write(input logic [7:0] a);
    own = a;
    mst.send(frm({a, 8'h06, 8'hf0, 8'h0b, 8'h12, 8'h34}), 90);
    expect_reply(frm({a, 8'h06, 8'hf0, 8'h0b, 8'h12, 8'h34}));
    check(last_wr, 32'hf00b_1234);
  endtask
  // broadcast write is carried out silently, broadcast read is dropped
  task automatic t_bcast();
    mst.send(frm({8'h00, 8'h06, 8'hf0, 8'h0c, 8'hbe, 8'hef}), 90);
    expect_reply(none);
    check(last_wr, 32'hf00c_beef);
    mst.send(frm({8'h00, 8'h03, 8'hf0, 8'h00, 8'h00, 8'h01}), 90);
    expect_reply(none);
    // a faulty broadcast must not draw an error reply either
    mst.send(frm({8'h00, 8'h04, 8'hf0, 8'h00, 8'h00, 8'h01}), 90);
    expect_reply(none);
  endtask
  // foreign address, bad check bytes, and a trailing byte that spoils the check
  task automatic t_reject();
    int  r = reqs;
    q8_t f = frm({own, 8'h03, 8'hf0, 8'h00, 8'h00, 8'h01});
    mst.send(frm({8'h22, 8'h03, 8'hf0, 8'h00, 8'h00, 8'h01}), 90);
    // 0x22 stands for another slave; addresses on the bus are unique
    expect_reply(none);
    check(reqs, r);
    f[6] = ~f[6];
    mst.send(f, 90);
    expect_reply(none);
    f[6] = ~f[6];
    f.push_back(8'h55);
    mst.send(f, 90);
    expect_reply(none);
    // an own address above the legal range matches nothing
    own = 8'hf8;
    mst.send(frm({8'hf8, 8'h03, 8'hf0, 8'h00, 8'h00, 8'h01}), 90);
    expect_reply(none);
    own = 8'h11;
  endtask
  // rows: command, count, store fault, reason code
  task automatic t_errors();
    logic [31:0] rows [5] = '{32'h0401_0001, 32'h0300_0003, 32'h030d_0003,
                              32'h0301_0102, 32'h0601_0102};
    foreach (rows[i])
    begin
      store_err = rows[i][8];
      mst.send(frm({own, rows[i][31:24], 8'hf0, 8'h00, 8'h00, rows[i][23:16]}), 90);
      expect_reply(frm({own, rows[i][31:24] | 8'h80, rows[i][7:0]}));
    end
    store_err = 1'b0;
    // good check but wrong length is answered; a runt frame is dropped
    mst.send(frm({own, 8'h06, 8'hf0, 8'h00, 8'h00}), 90);
    expect_reply(frm({own, 8'h86, 8'h03}));
    mst.send(frm({own}), 90);
    expect_reply(none);
  endtask
  // a pause between the short and long gap drops the partial frame
  task automatic t_restart();
    mst.send({own, 8'h03, 8'hf0}, 90);
    mst.send(frm({own, 8'h03, 8'hf0, 8'h05, 8'h00, 8'h01}), 50);
    expect_reply(frm({own, 8'h03, 8'h02, 8'h05, 8'hf0}));
  endtask
  initial
  begin
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (100) @(negedge clk_in);
    t_read(8'h02);
    t_read(8'h01);
    t_read(8'h0c);
    t_write(8'hf7);
    t_write(8'h11);
    t_bcast();
    t_reject();
    t_errors();
    t_restart();
    print_verdict();
  end
endmodule
bind rtu_slave_framer rtu_framer_chk chk
(
  .clk_in(clk_in), .rst_n_in(rst_n_in), .baud_div_in(baud_div_in),
  .char_bits_in(char_bits_in), .rx_valid_in(rx_valid_in), .tx_byte_out(tx_byte_out),
  .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .tx_enable_out(tx_enable_out),
  .param_req_out(param_req_out), .param_we_out(param_we_out),
  .param_group_out(param_group_out), .param_index_out(param_index_out),
  .param_ack_in(param_ack_in)
);
